// >>> verilog/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// How it works
// - One counter, 16 or 32 bits wide, fixed per instance by a parameter.
// - Up to three channels, each set to off, capture, compare or PWM.
// - Capture copies the counter into the channel buffer on the chosen input edge.
// - Compare drives the output high while the counter is at or above the threshold.
// - PWM output is high below a duty value reloaded from each new write at wrap.
// - Optional dead time delays the rising edge of both complementary outputs.
// - Counter advances on clock cycles or on a selected event source.
// - Overflow and channel events leave as one-cycle pulses on the reflex network.
`define TMR_CTRL_ADDR 8'h00
`define TMR_STATUS_ADDR 8'h04
`define TMR_COUNT_ADDR 8'h08
`define TMR_TOP_ADDR 8'h0C
`define TMR_DTIME_ADDR 8'h10
`define TMR_CH_AREA 3'h1
`define TMR_CTRL_EN_BIT 0
`define TMR_CTRL_SRC_LSB 1
`define TMR_CTRL_ONESHOT_BIT 3
`define TMR_CTRL_DOWN_BIT 4
`define TMR_CTRL_EVFALL_BIT 5
`define TMR_CTRL_DTEN_BIT 6
`define TMR_ST_OVF_BIT 0
`define TMR_ST_CAP_LSB 1
`define TMR_ST_MATCH_LSB 4
`define TMR_CHCFG_MODE_LSB 0
`define TMR_CHCFG_FALL_BIT 2
`define TMR_DTIME_W 8
`define TMR_DTIME_RST 8'h01
`endif

// >>> verilog/timer_pkg.sv
package timer_pkg;
  typedef enum logic [1:0] {
    CH_OFF = 2'h0,
    CH_CAPTURE = 2'h1,
    CH_COMPARE = 2'h2,
    CH_PWM = 2'h3
  } chan_mode_e;
  typedef enum logic [1:0] {
    SRC_CLOCK = 2'h0,
    SRC_PIN = 2'h1,
    SRC_REFLEX = 2'h2,
    SRC_NONE = 2'h3
  } count_src_e;
endpackage : timer_pkg

// >>> verilog/timer_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface timer_chan_if #(parameter int W = 16) ();
  logic [W-1:0] count;
  logic tick;
  logic wrap;
  logic cap_in;
  logic dt_en;
  logic [7:0] dtime;
  logic cfg_we;
  logic val_we;
  logic [31:0] wdata;
  logic [2:0] cfg;
  logic [W-1:0] val_rd;
  logic cap_ev;
  logic match_ev;
  logic out_p;
  logic out_n;
  modport core (
    output count, tick, wrap, cap_in, dt_en, dtime, cfg_we, val_we, wdata,
    input cfg, val_rd, cap_ev, match_ev, out_p, out_n
  );
  modport chan (
    input count, tick, wrap, cap_in, dt_en, dtime, cfg_we, val_we, wdata,
    output cfg, val_rd, cap_ev, match_ev, out_p, out_n
  );
endinterface : timer_chan_if
`default_nettype wire

// >>> verilog/timer_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
module timer_channel #(
  parameter int W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  timer_chan_if.chan cb
);
  typedef struct packed {
    timer_pkg::chan_mode_e mode;
    logic fall;
    logic [W-1:0] cmp;
    logic [W-1:0] duty;
    logic [W-1:0] cap;
    logic in_prev;
    logic raw;
    logic [7:0] dtc;
    logic op;
    logic on;
    logic cap_ev;
    logic match_ev;
  } chan_st_s;

  chan_st_s st_q;
  chan_st_s st_d;
  logic edge_seen;

  always_comb
  begin
    st_d = st_q;
    st_d.cap_ev = 1'b0;
    st_d.match_ev = 1'b0;
    edge_seen = st_q.fall ? (st_q.in_prev & ~cb.cap_in) : (~st_q.in_prev & cb.cap_in);
    st_d.in_prev = cb.cap_in;
    if (cb.cfg_we)
    begin
      st_d.mode = timer_pkg::chan_mode_e'(cb.wdata[`TMR_CHCFG_MODE_LSB +: 2]);
      st_d.fall = cb.wdata[`TMR_CHCFG_FALL_BIT];
    end
    if (cb.val_we)
      st_d.cmp = cb.wdata[W-1:0];
    case (st_q.mode)
      timer_pkg::CH_CAPTURE:
      begin
        st_d.raw = 1'b0;
        if (edge_seen)
        begin
          st_d.cap = cb.count;
          st_d.cap_ev = 1'b1;
        end
      end
      timer_pkg::CH_COMPARE:
      begin
        st_d.raw = (cb.count >= st_q.cmp);
        st_d.match_ev = cb.tick & (cb.count == st_q.cmp);
      end
      timer_pkg::CH_PWM:
      begin
        st_d.raw = (cb.count < st_q.duty);
        st_d.match_ev = cb.tick & (cb.count == st_q.duty);
        // Reload only at wrap so a period never mixes two duty values
        if (cb.wrap)
          st_d.duty = st_q.cmp;
      end
      default:
        st_d.raw = 1'b0;
    endcase
    if (st_q.mode != timer_pkg::CH_PWM)
      st_d.duty = st_q.cmp;
    if (st_d.raw != st_q.raw)
      st_d.dtc = 8'h00;
    else if (st_q.dtc < cb.dtime)
      st_d.dtc = st_q.dtc + 8'h01;
    if (cb.dt_en)
    begin
      st_d.op = st_d.raw & (st_d.dtc >= cb.dtime);
      st_d.on = ~st_d.raw & (st_d.dtc >= cb.dtime);
    end
    else
    begin
      st_d.op = st_d.raw;
      st_d.on = ~st_d.raw;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign cb.cfg = {st_q.fall, st_q.mode};
  assign cb.val_rd = (st_q.mode == timer_pkg::CH_CAPTURE) ? st_q.cap : st_q.cmp;
  assign cb.cap_ev = st_q.cap_ev;
  assign cb.match_ev = st_q.match_ev;
  assign cb.out_p = st_q.op;
  assign cb.out_n = st_q.on;

  default clocking cb_clk @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_capture_value: assert property (st_q.cap_ev |-> st_q.cap == $past(cb.count))
    else $error("capture buffer does not hold counter of edge cycle");
  chk_compare_level: assert property (
    $past(!cb.dt_en && st_q.mode == timer_pkg::CH_COMPARE) |->
      cb.out_p == ($past(cb.count) >= $past(st_q.cmp)))
    else $error("compare output disagrees with threshold");
  chk_pwm_level: assert property (
    $past(!cb.dt_en && st_q.mode == timer_pkg::CH_PWM) |->
      cb.out_p == ($past(cb.count) < $past(st_q.duty)))
    else $error("pwm output disagrees with duty");
  chk_pwm_reload: assert property (
    (cb.wrap && st_q.mode == timer_pkg::CH_PWM) |=> st_q.duty == $past(st_q.cmp))
    else $error("pwm duty not reloaded at wrap");
  chk_deadtime_gap: assert property (
    (cb.dt_en && cb.dtime != 8'h00 && $changed(st_q.raw)) |-> !cb.out_p && !cb.out_n)
    else $error("no dead time after output change");
endmodule : timer_channel
`default_nettype wire

// >>> verilog/timer_compare_capture_pwm.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
module timer_compare_capture_pwm #(
  parameter int CNT_W = 16,
  parameter int NCH = 3,
  parameter bit DEAD_TIME_OPT = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic event_pin_i,
  input wire logic reflex_in_i,
  input wire logic [NCH-1:0] ch_in_i,
  output logic [NCH-1:0] ch_out_o,
  output logic [NCH-1:0] ch_out_n_o,
  output logic reflex_ovf_o,
  output logic [NCH-1:0] reflex_cc_o
);
  typedef struct packed {
    logic en;
    timer_pkg::count_src_e src;
    logic oneshot;
    logic down;
    logic evfall;
    logic dten;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] top;
    logic [7:0] dtime;
    logic ovf;
    logic [NCH-1:0] capf;
    logic [NCH-1:0] mtchf;
    logic [1:0] ev_s;
    logic ev_prev;
    logic [NCH-1:0] in1;
    logic [NCH-1:0] in2;
    logic rflx_prev;
    logic ovf_pls;
    logic [31:0] rdata;
  } tmr_st_s;

  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  tmr_st_s st_q;
  tmr_st_s st_d;
  logic tick;
  logic at_end;
  logic wrap;
  logic ev_edge;
  logic rflx_edge;
  logic setup;
  logic wr;
  logic mapped;
  logic in_ch;
  logic [1:0] ch_idx;
  logic [31:0] rd_val;
  logic count_we;
  logic [NCH-1:0] wr_cfg;
  logic [NCH-1:0] wr_val;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match_ev;
  logic [NCH-1:0] out_p;
  logic [NCH-1:0] out_n;
  logic [2:0] ch_cfg [NCH];
  logic [CNT_W-1:0] ch_val [NCH];
  logic dt_en;

  assign ev_edge = st_q.evfall ? (st_q.ev_prev & ~st_q.ev_s[1]) : (~st_q.ev_prev & st_q.ev_s[1]);
  assign rflx_edge = st_q.evfall ? (st_q.rflx_prev & ~reflex_in_i)
    : (~st_q.rflx_prev & reflex_in_i);

  always_comb
  begin
    case (st_q.src)
      timer_pkg::SRC_CLOCK: tick = st_q.en;
      timer_pkg::SRC_PIN: tick = st_q.en & ev_edge;
      timer_pkg::SRC_REFLEX: tick = st_q.en & rflx_edge;
      default: tick = 1'b0;
    endcase
  end

  assign at_end = st_q.down ? (st_q.count == '0) : (st_q.count == st_q.top);
  assign wrap = tick & at_end;
  assign dt_en = DEAD_TIME_OPT & st_q.dten;

  // Zero wait states: read data are sampled in the setup cycle
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i & mapped;
  assign in_ch = (paddr_i[11:8] == 4'h0) && (paddr_i[7:5] == `TMR_CH_AREA);
  assign ch_idx = paddr_i[4:3];
  assign count_we = wr && (paddr_i[7:0] == `TMR_COUNT_ADDR) && (paddr_i[11:8] == 4'h0);

  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (in_ch && paddr_i[1:0] == 2'h0)
    begin
      if (32'(ch_idx) < NCH)
      begin
        if (paddr_i[2])
          rd_val = 32'(ch_val[ch_idx]);
        else
          rd_val = 32'(ch_cfg[ch_idx]);
      end
      else
        mapped = 1'b0;
    end
    else if (paddr_i[11:8] != 4'h0)
      mapped = 1'b0;
    else
    begin
      case (paddr_i[7:0])
        `TMR_CTRL_ADDR:
        begin
          rd_val[`TMR_CTRL_EN_BIT] = st_q.en;
          rd_val[`TMR_CTRL_SRC_LSB +: 2] = st_q.src;
          rd_val[`TMR_CTRL_ONESHOT_BIT] = st_q.oneshot;
          rd_val[`TMR_CTRL_DOWN_BIT] = st_q.down;
          rd_val[`TMR_CTRL_EVFALL_BIT] = st_q.evfall;
          rd_val[`TMR_CTRL_DTEN_BIT] = st_q.dten;
        end
        `TMR_STATUS_ADDR:
        begin
          rd_val[`TMR_ST_OVF_BIT] = st_q.ovf;
          rd_val[`TMR_ST_CAP_LSB +: NCH] = st_q.capf;
          rd_val[`TMR_ST_MATCH_LSB +: NCH] = st_q.mtchf;
        end
        `TMR_COUNT_ADDR: rd_val = 32'(st_q.count);
        `TMR_TOP_ADDR: rd_val = 32'(st_q.top);
        `TMR_DTIME_ADDR: rd_val = 32'(st_q.dtime);
        default: mapped = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      wr_cfg[n] = wr && in_ch && (32'(ch_idx) == n) && !paddr_i[2];
      wr_val[n] = wr && in_ch && (32'(ch_idx) == n) && paddr_i[2];
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.in1 = ch_in_i;
    st_d.in2 = st_q.in1;
    st_d.ev_s = {st_q.ev_s[0], event_pin_i};
    st_d.ev_prev = st_q.ev_s[1];
    st_d.rflx_prev = reflex_in_i;
    st_d.ovf_pls = wrap;
    if (tick)
    begin
      if (wrap)
      begin
        st_d.count = st_q.down ? st_q.top : '0;
        if (st_q.oneshot)
          st_d.en = 1'b0;
      end
      else if (st_q.down)
        st_d.count = st_q.count - ONE;
      else
        st_d.count = st_q.count + ONE;
    end
    if (setup)
      st_d.rdata = rd_val;
    if (wr && !in_ch)
    begin
      case (paddr_i[7:0])
        `TMR_CTRL_ADDR:
        begin
          st_d.en = pwdata_i[`TMR_CTRL_EN_BIT];
          st_d.src = timer_pkg::count_src_e'(pwdata_i[`TMR_CTRL_SRC_LSB +: 2]);
          st_d.oneshot = pwdata_i[`TMR_CTRL_ONESHOT_BIT];
          st_d.down = pwdata_i[`TMR_CTRL_DOWN_BIT];
          st_d.evfall = pwdata_i[`TMR_CTRL_EVFALL_BIT];
          st_d.dten = DEAD_TIME_OPT & pwdata_i[`TMR_CTRL_DTEN_BIT];
        end
        `TMR_COUNT_ADDR: st_d.count = pwdata_i[CNT_W-1:0];
        `TMR_TOP_ADDR: st_d.top = pwdata_i[CNT_W-1:0];
        `TMR_DTIME_ADDR: st_d.dtime = pwdata_i[`TMR_DTIME_W-1:0];
        default: st_d.count = st_d.count;
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle keeps its flag
    if (wr && !in_ch && paddr_i[7:0] == `TMR_STATUS_ADDR)
    begin
      st_d.ovf = st_q.ovf & ~pwdata_i[`TMR_ST_OVF_BIT];
      st_d.capf = st_q.capf & ~pwdata_i[`TMR_ST_CAP_LSB +: NCH];
      st_d.mtchf = st_q.mtchf & ~pwdata_i[`TMR_ST_MATCH_LSB +: NCH];
    end
    st_d.ovf = st_d.ovf | wrap;
    st_d.capf = st_d.capf | cap_ev;
    st_d.mtchf = st_d.mtchf | match_ev;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.top <= '1;
      st_q.dtime <= `TMR_DTIME_RST;
    end
    else
      st_q <= st_d;
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    timer_chan_if #(.W(CNT_W)) cif ();
    assign cif.count = st_q.count;
    assign cif.tick = tick;
    assign cif.wrap = wrap;
    assign cif.cap_in = st_q.in2[g];
    assign cif.dt_en = dt_en;
    assign cif.dtime = st_q.dtime;
    assign cif.cfg_we = wr_cfg[g];
    assign cif.val_we = wr_val[g];
    assign cif.wdata = pwdata_i;
    assign ch_cfg[g] = cif.cfg;
    assign ch_val[g] = cif.val_rd;
    assign cap_ev[g] = cif.cap_ev;
    assign match_ev[g] = cif.match_ev;
    assign out_p[g] = cif.out_p;
    assign out_n[g] = cif.out_n;
    timer_channel #(.W(CNT_W)) u_chan (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .cb(cif.chan)
    );
  end

  assign prdata_o = st_q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign ch_out_o = out_p;
  assign ch_out_n_o = out_n;
  assign reflex_ovf_o = st_q.ovf_pls;
  assign reflex_cc_o = cap_ev | match_ev;

  default clocking cb_clk @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wrap_up;
    wrap && !st_q.down && !count_we;
  endsequence
  sequence s_step_up;
    tick && !at_end && !st_q.down && !count_we;
  endsequence

  chk_counter_wrap: assert property (s_wrap_up |=> st_q.count == '0 && st_q.ovf)
    else $error("counter did not wrap to zero with overflow flag");
  chk_counter_step: assert property (s_step_up |=> st_q.count == $past(st_q.count) + ONE)
    else $error("counter did not step by one");
  chk_reflex_ovf: assert property (reflex_ovf_o == $past(wrap))
    else $error("overflow trigger pulse misplaced");
  chk_hold_idle: assert property ((!st_q.en && !count_we) |=> $stable(st_q.count))
    else $error("counter moved while stopped");
  chk_pin_event: assert property (
    (st_q.en && st_q.src == timer_pkg::SRC_PIN && !ev_edge && !count_we) |=>
      $stable(st_q.count))
    else $error("counter moved without an event");
  chk_reflex_edge_count: assert property (
    (st_q.en && st_q.src == timer_pkg::SRC_REFLEX && !rflx_edge && !count_we) |=>
      $stable(st_q.count))
    else $error("counter moved without a reflex event");
  chk_ovf_sticky: assert property (
    (st_q.ovf && !(wr && paddr_i[7:0] == `TMR_STATUS_ADDR)) |=> st_q.ovf)
    else $error("overflow flag lost without a clear");
  chk_width_ok: assert property ((CNT_W == 16 || CNT_W == 32) && NCH >= 1 && NCH <= 3)
    else $error("unsupported counter width or channel count");

  // Software may preload the counter at any time, so a count write masks the step checks
  sequence s_wrap_down;
    wrap && st_q.down && !count_we;
  endsequence

  chk_down_reload: assert property (s_wrap_down |=> st_q.count == $past(st_q.top))
    else $error("down counter did not reload top");
  chk_count_write: assert property (count_we |=> st_q.count == CNT_W'($past(pwdata_i)))
    else $error("counter write not applied");
  chk_oneshot_stop: assert property (
    (wrap && st_q.oneshot && !(wr && !in_ch && paddr_i[7:0] == `TMR_CTRL_ADDR)) |=> !st_q.en)
    else $error("one-shot counter kept running after wrap");
  // Set wins over clear, so the clear is only checked in a cycle without a wrap
  chk_ovf_clear: assert property (
    (wr && !in_ch && paddr_i[7:0] == `TMR_STATUS_ADDR && pwdata_i[`TMR_ST_OVF_BIT] &&
      !wrap) |=> !st_q.ovf)
    else $error("overflow flag not cleared by write");
  chk_cap_flag: assert property ((|cap_ev) |=> (st_q.capf & $past(cap_ev)) == $past(cap_ev))
    else $error("capture flag not raised");
  chk_match_flag: assert property (
    (|match_ev) |=> (st_q.mtchf & $past(match_ev)) == $past(match_ev))
    else $error("match flag not raised");
  chk_bus_error: assert property ((psel_i && penable_i && paddr_i[11:8] != 4'h0) |-> pslverr_o)
    else $error("unmapped access not refused");
endmodule : timer_compare_capture_pwm
`default_nettype wire

// >>> sim/timer_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module timer_far_side (
  input wire logic core_clk_i,
  output logic event_pin_o,
  output logic reflex_o,
  output logic [2:0] ch_in_o
);
  initial
  begin
    event_pin_o = 1'b0;
    reflex_o = 1'b0;
    ch_in_o = 3'h0;
  end
  // Long highs and lows so the pin survives the two-stage synchroniser
  task automatic pulses(input bit pin, input int n);
    repeat (n)
    begin
      @(posedge core_clk_i);
      if (pin)
        event_pin_o <= 1'b1;
      else
        reflex_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      event_pin_o <= 1'b0;
      reflex_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
  endtask : pulses
  task automatic flip(input int ch);
    @(posedge core_clk_i);
    ch_in_o[ch] <= ~ch_in_o[ch];
  endtask : flip
endmodule : timer_far_side
`default_nettype wire

// >>> sim/timer_compare_capture_pwm_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
module timer_compare_capture_pwm_tb;
  logic clk;
  logic rst;
  logic psel;
  logic pen;
  logic pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic ev;
  logic rfx;
  logic [2:0] chin;
  logic [2:0] chout;
  logic [2:0] choutn;
  logic rovf;
  logic [2:0] rcc;
  logic [31:0] rv;
  logic err;
  int n_mismatch;
  int num_checks;
  int n;
  int hi;
  int cc;
  timer_compare_capture_pwm #(.CNT_W(16), .NCH(3), .DEAD_TIME_OPT(1'b1))
    timer_compare_capture_pwm_i (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .event_pin_i(ev),
    .reflex_in_i(rfx), .ch_in_i(chin), .ch_out_o(chout),
    .ch_out_n_o(choutn), .reflex_ovf_o(rovf), .reflex_cc_o(rcc)
  );
  timer_far_side timer_far_side_i (
    .core_clk_i(clk), .event_pin_o(ev), .reflex_o(rfx), .ch_in_o(chin)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rv = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rv, exp);
  endtask : rd
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc
  // Returns the number of cycles since the call, bounded
  task automatic wait_ovf();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rovf !== 1'b1 && n < 60);
    if (rovf !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : wait_ovf
  task automatic pwm_highs();
    wait_ovf();
    wait_ovf();
    hi = 0;
    cc = 0;
    repeat (10)
    begin
      @(negedge clk);
      hi += (chout[2] === 1'b1) ? 1 : 0;
      cc += (rcc[2] === 1'b1) ? 1 : 0;
    end
  endtask : pwm_highs
  // Counts the cycles in which one channel's reflex pulse stands
  task automatic count_cc(input int ch, input int c);
    cc = 0;
    repeat (c)
    begin
      @(negedge clk);
      cc += (rcc[ch] === 1'b1) ? 1 : 0;
    end
  endtask : count_cc
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    check({26'h0, chout, choutn}, 32'h7);
    rd(`TMR_CTRL_ADDR, 32'h0);
    check({31'h0, err}, 32'h0);
    rd(`TMR_STATUS_ADDR, 32'h0);
    rd(`TMR_TOP_ADDR, 32'h0000FFFF);
    rd(`TMR_DTIME_ADDR, 32'h1);
    rd(12'h038, 32'h0);
    check({31'h0, err}, 32'h1);
    rd(12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(`TMR_COUNT_ADDR, 32'hFFFFFFFF);
    rd(`TMR_COUNT_ADDR, 32'h0000FFFF);
    for (int s = 1; s < 4; s++)
    begin
      wr(`TMR_COUNT_ADDR, 32'h0);
      wr(`TMR_CTRL_ADDR, 32'h1 | (s << 1) | ((s == 2) ? 32'h20 : 32'h0));
      timer_far_side_i.pulses(s == 1, 3);
      wr(`TMR_CTRL_ADDR, 32'h0);
      rd(`TMR_COUNT_ADDR, (s == 3) ? 32'h0 : 32'h3);
    end
    wr(`TMR_TOP_ADDR, 32'h2);
    wr(`TMR_COUNT_ADDR, 32'h0);
    wr(`TMR_CTRL_ADDR, 32'h1);
    wait_ovf();
    wait_ovf();
    check(n, 32'h3);
    wr(`TMR_CTRL_ADDR, 32'h0);
    apb(1'b0, `TMR_STATUS_ADDR, 32'h0);
    check(rv & 32'h1, 32'h1);
    wr(`TMR_STATUS_ADDR, 32'h1);
    apb(1'b0, `TMR_STATUS_ADDR, 32'h0);
    check(rv & 32'h1, 32'h0);
    wr(12'h028, 32'h2);
    wr(12'h02C, 32'h5);
    wr(`TMR_COUNT_ADDR, 32'h7);
    cyc(4);
    check({chout[1], choutn[1]}, 32'h2);
    wr(`TMR_COUNT_ADDR, 32'h3);
    cyc(4);
    check({chout[1], choutn[1]}, 32'h1);
    wr(`TMR_DTIME_ADDR, 32'h3);
    wr(`TMR_CTRL_ADDR, 32'h40);
    cyc(8);
    wr(`TMR_COUNT_ADDR, 32'h7);
    cyc(3);
    check({chout[1], choutn[1]}, 32'h0);
    cyc(8);
    check({chout[1], choutn[1]}, 32'h2);
    wr(`TMR_TOP_ADDR, 32'h9);
    wr(`TMR_COUNT_ADDR, 32'h0);
    wr(12'h030, 32'h3);
    wr(12'h034, 32'h4);
    wr(`TMR_CTRL_ADDR, 32'h1);
    pwm_highs();
    check(hi, 32'h4);
    check(cc, 32'h1);
    wr(12'h034, 32'h7);
    pwm_highs();
    check(hi, 32'h7);
    check(cc, 32'h1);
    wr(`TMR_CTRL_ADDR, 32'h0);
    wr(`TMR_COUNT_ADDR, 32'h1234);
    wr(12'h020, 32'h1);
    wr(`TMR_STATUS_ADDR, 32'h7F);
    timer_far_side_i.flip(0);
    count_cc(0, 8);
    check(cc, 32'h1);
    rd(12'h024, 32'h1234);
    apb(1'b0, `TMR_STATUS_ADDR, 32'h0);
    check(rv & 32'h2, 32'h2);
    rd(12'h020, 32'h1);
    rd(12'h028, 32'h2);
    rd(12'h030, 32'h3);
    wr(12'h020, 32'h5);
    wr(`TMR_COUNT_ADDR, 32'h55AA);
    timer_far_side_i.flip(0);
    count_cc(0, 8);
    check(cc, 32'h1);
    rd(12'h024, 32'h55AA);
    wr(`TMR_TOP_ADDR, 32'h2);
    wr(`TMR_COUNT_ADDR, 32'h2);
    wr(`TMR_CTRL_ADDR, 32'h19);
    wait_ovf();
    check(n, 32'h4);
    rd(`TMR_CTRL_ADDR, 32'h18);
    rd(`TMR_COUNT_ADDR, 32'h2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    check({26'h0, chout, choutn}, 32'h7);
    rd(`TMR_STATUS_ADDR, 32'h0);
    rd(`TMR_TOP_ADDR, 32'h0000FFFF);
    tally_and_finish();
  end
endmodule : timer_compare_capture_pwm_tb
`default_nettype wire
